//--- logic/hb_switch_ctrl.sv
// Half-bridge switching sequencer with Avalon-MM register slave
// Functional notes
// - High gate off when sense exceeds high
// - Dead time before low gate on
// - Low gate off when sense below low
// - Dead time before high gate; frequency results
// - Spread derived from feedback optocurrent
// - Less feedback current widens spread
// - Optocurrent regulated toward 85 microamperes
// - Start-up ramps spread slowly from strap value
// - Start spread taken from strap setting
// - Maximum demand gives widest threshold pair
// - Enter low power below entry level
// - Low power entry enlarges spread at once
// - Shrink spread first, then cut duty
// - Longest low-power period hands to burst
// - Off state: low gate on, high off
// - Minimum on-time before ending conduction
// - Conduction ends on first terminating event
// - Ignore node until minimum non-overlap passes
// - Advance on node peak with nonpositive current
// - Max non-overlap advance with nonpositive current
// - High-side states mirror low-side states
// - Low power: low,high,low then third hold
// - Low-power frequency never below 23 kHz
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module hb_switch_ctrl
  import hb_ctrl_pkg::*;
#(
  parameter logic [TW-1:0] LP_PERIOD_MAX = TW'(LP_PERIOD_MAX_CYC)
) (
  input wire logic clk, // System clock, 250 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [2:0] address, // Avalon word address
  input wire logic read, // Avalon read strobe
  input wire logic write, // Avalon write strobe
  input wire logic [31:0] writedata, // Avalon write data
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon stall
  input wire logic [CW-1:0] capSense, // Divided capacitor voltage
  input wire logic [CW-1:0] fbCurrent, // Feedback optocurrent code
  input wire logic [CW-1:0] startSetting, // Strapped start spread
  input wire logic hbPeak, // Node peak seen
  input wire logic resCurrentNeg, // Resonant current zero or negative
  input wire logic overcurrentDetect, // Overcurrent seen
  input wire logic nearCapacitive, // Close to capacitive mode
  output logic lowSideGate, // Low-side gate drive
  output logic highSideGate, // High-side gate drive
  output logic lowPowerMode, // Low-power mode active
  output logic burstRequest // Hand-off to burst mode
);
  spread_if sp ();
  sw_state_t state_ff, nxt_state;
  logic enable_ff;
  logic [CW-1:0] lpLevel_ff;
  logic [TW-1:0] tonMin_ff, tonMax_ff, tnoMin_ff, tnoMax_ff;
  logic [TW-1:0] timer_ff;
  logic peakSeen_ff;
  logic [CW-1:0] startSpread_ff;
  logic startValid_ff;
  logic [1:0] halfCnt_ff;
  logic [TW-1:0] active_ff;
  logic [TW-1:0] extra_ff;
  logic [TW-1:0] holdLen_ff;
  logic burst_ff;
  logic lsGate_ff, hsGate_ff, lp_ff;
  logic [31:0] readdata_ff;
  logic waitreq_ff;
  logic onExit, noExit, lastHalf, cycleStart;
  logic [TW:0] period;

  spread_gen u_spread (
    .clk(clk),
    .rst(rst),
    .sp(sp)
  );

  // Register read mux, decoded for readdata only
  function automatic logic [31:0] reg_read(input logic [2:0] a);
    case (a)
      REG_CTRL: reg_read = {31'h0, enable_ff};
      REG_LP_LEVEL: reg_read = {22'h0, lpLevel_ff};
      REG_TON_MIN: reg_read = {16'h0, tonMin_ff};
      REG_TON_MAX: reg_read = {16'h0, tonMax_ff};
      REG_TNO_MIN: reg_read = {16'h0, tnoMin_ff};
      REG_TNO_MAX: reg_read = {16'h0, tnoMax_ff};
      REG_STATUS: reg_read = {27'h0, burst_ff, lp_ff, state_ff};
      REG_THRESH: reg_read = {6'h0, sp.capHigh, 6'h0, sp.capLow};
      default: reg_read = 32'h0;
    endcase
  endfunction

  // Bus slave: one stall cycle, then the word is answered
  always_ff @(posedge clk) begin
    if (rst) begin
      waitreq_ff <= 1'b1;
      readdata_ff <= 32'h0;
    end else if ((read || write) && waitreq_ff) begin
      waitreq_ff <= 1'b0;
      readdata_ff <= read ? reg_read(address) : 32'h0;
    end else begin
      waitreq_ff <= 1'b1;
    end
  end

  // Writes take effect on the edge that completes the transfer
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_ff <= 1'b0;
      lpLevel_ff <= LP_LEVEL_RST;
      tonMin_ff <= TON_MIN_RST;
      tonMax_ff <= TON_MAX_RST;
      tnoMin_ff <= TNO_MIN_RST;
      tnoMax_ff <= TNO_MAX_RST;
    end else if (write && !waitreq_ff) begin
      case (address)
        REG_CTRL: enable_ff <= writedata[0];
        REG_LP_LEVEL: lpLevel_ff <= writedata[CW-1:0];
        REG_TON_MIN: tonMin_ff <= writedata[TW-1:0];
        REG_TON_MAX: tonMax_ff <= writedata[TW-1:0];
        REG_TNO_MIN: tnoMin_ff <= writedata[TW-1:0];
        REG_TNO_MAX: tnoMax_ff <= writedata[TW-1:0];
        default: ;
      endcase
    end
  end

  // Strap caught once after reset release, never under reset itself
  always_ff @(posedge clk) begin
    if (rst) begin
      startSpread_ff <= '0;
      startValid_ff <= 1'b0;
    end else if (!startValid_ff) begin
      startSpread_ff <= startSetting;
      startValid_ff <= 1'b1;
    end
  end

  assign sp.fbCurrent = fbCurrent;
  assign sp.startSpread = startSpread_ff;
  assign sp.startValid = startValid_ff;
  assign sp.lpLevel = lpLevel_ff;
  assign sp.boundary = (nxt_state != state_ff);

  // End of conduction: minimum on-time gates every other cause
  always_comb begin
    onExit = 1'b0;
    if (timer_ff >= tonMin_ff) begin
      onExit = overcurrentDetect || nearCapacitive ||
               timer_ff >= tonMax_ff;
      if (state_ff == ST_LS_ON && capSense < sp.capLow) onExit = 1'b1;
      if (state_ff == ST_HS_ON && capSense > sp.capHigh) onExit = 1'b1;
    end
  end

  // Non-overlap ends on a late peak or on timeout, never on positive current
  assign noExit = resCurrentNeg && timer_ff >= tnoMin_ff &&
                  (peakSeen_ff || hbPeak || timer_ff >= tnoMax_ff);
  assign lastHalf = lp_ff && halfCnt_ff == LP_HALF_CYCLES - 2'h1;

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_LS_ON: if (enable_ff && onExit) nxt_state = ST_LS_NO;
      ST_LS_NO: begin
        if (noExit) nxt_state = lastHalf ? ST_HOLD : ST_HS_ON;
      end
      ST_HS_ON: if (onExit) nxt_state = ST_HS_NO;
      ST_HS_NO: if (noExit) nxt_state = ST_LS_ON;
      ST_HOLD: if (timer_ff >= holdLen_ff) nxt_state = ST_LS_ON;
      default: nxt_state = ST_LS_ON;
    endcase
    if (!enable_ff) nxt_state = ST_LS_ON;
  end

  // State, timer and peak capture
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_LS_ON;
      timer_ff <= '0;
      peakSeen_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= (nxt_state != state_ff) ? '0 : timer_ff + 16'h0001;
      // Node is blind until minimum non-overlap has passed
      peakSeen_ff <= (nxt_state != state_ff) ? 1'b0 :
                     peakSeen_ff || (hbPeak && timer_ff >= tnoMin_ff);
    end
  end

  // Gate outputs follow the next state so they switch with it
  always_ff @(posedge clk) begin
    if (rst) begin
      lsGate_ff <= 1'b1;
      hsGate_ff <= 1'b0;
    end else begin
      lsGate_ff <= (nxt_state == ST_LS_ON);
      hsGate_ff <= (nxt_state == ST_HS_ON);
    end
  end

  // Low-power cycle: count half-cycles and active time, size the hold
  assign period = {1'b0, active_ff} + {1'b0, holdLen_ff};
  // In low power the middle return to LS_ON is not a fresh cycle
  assign cycleStart = state_ff != ST_LS_ON && nxt_state == ST_LS_ON &&
                      (!lp_ff || state_ff == ST_HOLD);
  always_ff @(posedge clk) begin
    if (rst || !enable_ff) begin
      halfCnt_ff <= '0;
      active_ff <= '0;
      holdLen_ff <= '0;
      lp_ff <= 1'b0;
    end else begin
      // Mode is sampled only when a fresh switching cycle starts
      if (cycleStart) begin
        lp_ff <= sp.lpMode;
        halfCnt_ff <= '0;
      end else if ((state_ff == ST_LS_NO || state_ff == ST_HS_NO) &&
                   nxt_state != state_ff) begin
        halfCnt_ff <= halfCnt_ff + 2'h1;
      end
      // Active time restarts with each cycle so the hold stays a third
      if (cycleStart) active_ff <= '0;
      else if (state_ff != ST_HOLD && active_ff != 16'hFFFF)
        active_ff <= active_ff + 16'h0001;
      // Hold of half the active time gives the two-thirds duty
      if (nxt_state == ST_HOLD && state_ff != ST_HOLD)
        holdLen_ff <= {1'b0, active_ff[TW-1:1]} + extra_ff;
    end
  end

  // Duty regulation: longer hold up to the audible-band limit
  always_ff @(posedge clk) begin
    if (rst || !lp_ff) begin
      extra_ff <= '0;
      burst_ff <= 1'b0;
    end else if (state_ff == ST_HOLD && nxt_state != ST_HOLD) begin
      if (sp.dutyDown && period < {1'b0, LP_PERIOD_MAX}) begin
        extra_ff <= extra_ff + 16'h0001;
        burst_ff <= 1'b0;
      end else begin
        if (!sp.dutyDown && extra_ff != '0) extra_ff <= extra_ff - 16'h0001;
        burst_ff <= sp.dutyDown;
      end
    end
  end

  assign readdata = readdata_ff;
  assign waitrequest = waitreq_ff;
  assign lowSideGate = lsGate_ff;
  assign highSideGate = hsGate_ff;
  assign lowPowerMode = lp_ff;
  assign burstRequest = burst_ff;

  // Checks beside the sequencer
  a_gates_exclusive: assert property (@(posedge clk) disable iff (rst)
    !(lowSideGate && highSideGate))
    else $error("both gates on");
  a_hs_off_high: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_HS_ON && enable_ff && timer_ff >= tonMin_ff &&
     capSense > sp.capHigh)
    |=> state_ff == ST_HS_NO ##1 !highSideGate)
    else $error("high gate kept past high threshold");
  a_ls_off_low: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_LS_ON && enable_ff && timer_ff >= tonMin_ff &&
     capSense < sp.capLow) |=> state_ff == ST_LS_NO)
    else $error("low gate kept past low threshold");
  a_min_on_time: assert property (@(posedge clk) disable iff (rst)
    (state_ff inside {ST_LS_ON, ST_HS_ON} && enable_ff &&
     timer_ff < tonMin_ff) |=> state_ff == $past(state_ff))
    else $error("conduction cut before minimum on-time");
  a_no_min_wait: assert property (@(posedge clk) disable iff (rst)
    (state_ff inside {ST_LS_NO, ST_HS_NO} && timer_ff < tnoMin_ff &&
     enable_ff) |=> state_ff == $past(state_ff))
    else $error("non-overlap ended early");
  a_no_cur_pos: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_HS_NO && !resCurrentNeg && enable_ff)
    |=> state_ff == ST_HS_NO)
    else $error("advanced with positive resonant current");
  a_no_timeout: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_HS_NO && enable_ff && resCurrentNeg &&
     timer_ff >= tnoMax_ff) |=> state_ff == ST_LS_ON ##1 lowSideGate)
    else $error("max non-overlap did not advance");
  a_off_state: assert property (@(posedge clk) disable iff (rst)
    !enable_ff ##1 !enable_ff |=> lowSideGate && !highSideGate)
    else $error("off state gates wrong");
  a_thr_stable: assert property (@(posedge clk) disable iff (rst)
    !sp.boundary |=> $stable(sp.capHigh) && $stable(sp.capLow))
    else $error("threshold moved mid state");
  a_hold_shape: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_LS_NO && nxt_state == ST_HOLD) |-> lp_ff &&
     halfCnt_ff == 2'h2)
    else $error("hold entered off the third half-cycle");
  a_lp_period: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_HOLD && nxt_state != ST_HOLD && sp.dutyDown &&
     period >= {1'b0, LP_PERIOD_MAX}) |=> burstRequest)
    else $error("low-power period beyond limit");

  c_hp_cycle: cover property (@(posedge clk) disable iff (rst)
    state_ff == ST_HS_NO ##1 state_ff == ST_LS_ON);
  c_lp_hold: cover property (@(posedge clk) disable iff (rst)
    state_ff == ST_LS_NO ##1 state_ff == ST_HOLD);
  c_burst: cover property (@(posedge clk) disable iff (rst) $rose(burst_ff));
  c_peak_adv: cover property (@(posedge clk) disable iff (rst)
    state_ff == ST_LS_NO && hbPeak && noExit);
endmodule // hb_switch_ctrl
`default_nettype wire

//--- logic/hb_ctrl_pkg.sv
// Constants, register map and state encoding of the half-bridge controller
package hb_ctrl_pkg;
  // Data widths
  localparam int CW = 10;
  localparam int TW = 16;
  // Clock and time figures
  localparam int CLK_KHZ = 250000;
  localparam int LP_MIN_FREQ_KHZ = 23;
  // Longest low-power period, rounded down to whole cycles
  localparam int LP_PERIOD_MAX_CYC = CLK_KHZ / LP_MIN_FREQ_KHZ;
  // Feedback optocurrent target and code step
  localparam int FB_TARGET_UA = 85;
  localparam int FB_LSB_UA = 1;
  localparam logic [CW-1:0] FB_TARGET = CW'(FB_TARGET_UA / FB_LSB_UA);
  localparam logic [CW-1:0] FB_FULL = 10'h3FF;
  // Threshold geometry on the divided capacitor sense scale
  localparam logic [CW-1:0] CAP_MID = 10'h200;
  localparam logic [CW-1:0] SPREAD_MAX = 10'h380;
  localparam logic [CW-1:0] LP_SPREAD_MIN = 10'h040;
  localparam logic [CW-1:0] OFFSET_MAX = 10'h0FF;
  localparam logic [CW-1:0] LP_HYST = 10'h010;
  // Slow ramp and optobias step interval
  localparam logic [TW-1:0] RAMP_STEP_CYC = 16'h00FF;
  // Low-power cycle shape
  localparam logic [1:0] LP_HALF_CYCLES = 2'h3;
  // Register word indices
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_LP_LEVEL = 3'h1;
  localparam logic [2:0] REG_TON_MIN = 3'h2;
  localparam logic [2:0] REG_TON_MAX = 3'h3;
  localparam logic [2:0] REG_TNO_MIN = 3'h4;
  localparam logic [2:0] REG_TNO_MAX = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;
  localparam logic [2:0] REG_THRESH = 3'h7;
  // Values after reset
  localparam logic [CW-1:0] LP_LEVEL_RST = 10'h080;
  localparam logic [TW-1:0] TON_MIN_RST = 16'h0040;
  localparam logic [TW-1:0] TON_MAX_RST = 16'h1000;
  localparam logic [TW-1:0] TNO_MIN_RST = 16'h0008;
  localparam logic [TW-1:0] TNO_MAX_RST = 16'h0080;
  // Switching states, Gray coded around the four-state ST_LS_ON to ST_HS_NO loop; ST_HOLD is not adjacent
  typedef enum logic [2:0] {
    ST_LS_ON = 3'h0,
    ST_LS_NO = 3'h1,
    ST_HS_ON = 3'h3,
    ST_HS_NO = 3'h2,
    ST_HOLD = 3'h6
  } sw_state_t;
endpackage

//--- logic/spread_if.sv
// Interface between the switching sequencer and the threshold generator
`timescale 1ns/1ns
`default_nettype none
interface spread_if;
  import hb_ctrl_pkg::*;
  logic [CW-1:0] fbCurrent;
  logic [CW-1:0] startSpread;
  logic [CW-1:0] lpLevel;
  logic startValid;
  logic boundary;
  logic [CW-1:0] capHigh;
  logic [CW-1:0] capLow;
  logic lpMode;
  logic dutyDown;
  modport gen (input fbCurrent, startSpread, lpLevel, startValid, boundary,
               output capHigh, capLow, lpMode, dutyDown);
  modport ctl (output fbCurrent, startSpread, lpLevel, startValid, boundary,
               input capHigh, capLow, lpMode, dutyDown);
endinterface
`default_nettype wire

//--- logic/spread_gen.sv
// Threshold spread generator: optobias, start ramp, low-power decision
`timescale 1ns/1ns
`default_nettype none
module spread_gen
  import hb_ctrl_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  spread_if.gen sp // Link to sequencer
);
  logic [TW-1:0] tick_ff;
  logic [CW-1:0] offset_ff;
  logic [CW-1:0] ramp_ff;
  logic rampDone_ff;
  logic lp_ff;
  logic [CW-1:0] capHigh_ff;
  logic [CW-1:0] capLow_ff;
  logic [CW:0] demandWide;
  logic [CW-1:0] demand;
  logic [CW-1:0] spreadReq;
  logic [CW:0] lpWide;
  logic [CW-1:0] spread;
  logic [CW-1:0] half;
  logic tick;

  // Slow step timer shared by ramp and optobias loop
  always_ff @(posedge clk) begin
    if (rst || tick) tick_ff <= '0;
    else tick_ff <= tick_ff + 16'h0001;
  end
  assign tick = (tick_ff == RAMP_STEP_CYC);

  // Optocurrent slowly pulled toward its fixed target
  always_ff @(posedge clk) begin
    if (rst) offset_ff <= '0;
    else if (tick && sp.fbCurrent < FB_TARGET && offset_ff < OFFSET_MAX)
      offset_ff <= offset_ff + 10'h001;
    else if (tick && sp.fbCurrent > FB_TARGET && offset_ff != '0)
      offset_ff <= offset_ff - 10'h001;
  end

  // Less current out of the feedback pin means more demanded power
  assign demandWide = {1'b0, FB_FULL - sp.fbCurrent} + {1'b0, offset_ff};
  assign demand = demandWide[CW] ? FB_FULL : demandWide[CW-1:0];

  // Start ramp begins at the strapped value and climbs to regulation
  always_ff @(posedge clk) begin
    if (rst || !sp.startValid) begin
      ramp_ff <= '0;
      rampDone_ff <= 1'b0;
    end else if (ramp_ff == '0 && !rampDone_ff) begin
      ramp_ff <= sp.startSpread;
      rampDone_ff <= (sp.startSpread >= demand);
    end else if (tick && !rampDone_ff) begin
      ramp_ff <= ramp_ff + 10'h001;
      rampDone_ff <= (ramp_ff + 10'h001 >= demand);
    end
  end
  assign spreadReq = (!rampDone_ff && ramp_ff < demand) ? ramp_ff : demand;

  // Mode transition with a little hysteresis to avoid chatter
  always_ff @(posedge clk) begin
    if (rst) lp_ff <= 1'b0;
    else if (rampDone_ff && spreadReq < sp.lpLevel) lp_ff <= 1'b1;
    else if ({1'b0, spreadReq} > {1'b0, sp.lpLevel} + {1'b0, LP_HYST})
      lp_ff <= 1'b0;
  end

  // Hold takes a third of the time, so energy per cycle rises by half
  assign lpWide = {1'b0, spreadReq} + {2'b00, spreadReq[CW-1:1]};
  always_comb begin
    spread = lp_ff ? lpWide[CW-1:0] : spreadReq;
    // A carry out means a very wide spread, never a narrow one
    if (lp_ff && lpWide[CW]) spread = SPREAD_MAX;
    else if (lp_ff && lpWide[CW-1:0] < LP_SPREAD_MIN)
      spread = LP_SPREAD_MIN;
    if (spread > SPREAD_MAX) spread = SPREAD_MAX;
  end
  assign half = {1'b0, spread[CW-1:1]};

  // New thresholds only land at a switching-state boundary
  always_ff @(posedge clk) begin
    if (rst) begin
      capHigh_ff <= CAP_MID;
      capLow_ff <= CAP_MID;
    end else if (sp.boundary) begin
      capHigh_ff <= CAP_MID + half;
      capLow_ff <= CAP_MID - half;
    end
  end

  assign sp.capHigh = capHigh_ff;
  assign sp.capLow = capLow_ff;
  assign sp.lpMode = lp_ff;
  assign sp.dutyDown = lp_ff && !lpWide[CW] &&
                       lpWide[CW-1:0] < LP_SPREAD_MIN;
endmodule // spread_gen
`default_nettype wire

//--- tb/hb_far_side.sv
// Far-side model: resonant tank voltage, node peak and current sign
`timescale 1ns/1ns
`default_nettype none
module hb_far_side
  import hb_ctrl_pkg::*;
#(
  parameter int PK = 3
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic ls, // Low-side gate
  input wire logic hs, // High-side gate
  input wire logic peakOff, // Suppress the node peak
  input wire logic resBlock, // Keep resonant current positive
  output logic [CW-1:0] cap, // Divided capacitor voltage
  output logic peak, // Node peak seen
  output logic resNeg // Current zero or negative
);
  int gap;
  // Tank charges while high side conducts, discharges on low side
  always @(posedge clk) begin
    if (rst) cap <= 10'h200;
    else if (hs && cap < 10'h3FB) cap <= cap + 10'h004;
    else if (ls && cap > 10'h004) cap <= cap - 10'h004;
    gap <= (ls || hs) ? 0 : gap + 1;
  end
  // Peak needs time to swing, so an early look sees nothing
  assign peak = !peakOff && !ls && !hs && gap >= PK;
  assign resNeg = !resBlock;
endmodule // hb_far_side
`default_nettype wire

//--- tb/tb_hb_switch_ctrl.sv
// Self-checking bench for the half-bridge switching sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_hb_switch_ctrl;
  import hb_ctrl_pkg::*;
  localparam int TMIN = 32;
  localparam int TMAX = 256;
  localparam int NMIN = 8;
  localparam int NMAX = 64;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [2:0] address = 3'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, lowSideGate, highSideGate, lowPowerMode, burstRequest;
  logic [CW-1:0] capSense, capModel;
  logic [CW-1:0] capFix = 10'h000;
  logic [CW-1:0] fbCurrent = FB_TARGET;
  logic [CW-1:0] startSetting = 10'h37C;
  logic useModel = 1'h0;
  logic overcurrentDetect = 1'h0;
  logic nearCapacitive = 1'h0;
  logic peakOff = 1'h0;
  logic resBlock = 1'h0;
  logic hbPeak, resCurrentNeg;
  int error_cnt = 0;
  int n_tests = 0;
  int t;
  // 250 MHz clock
  always #2 clk = ~clk;
  // Fixed sense level lets a scenario pin one threshold decision
  assign capSense = useModel ? capModel : capFix;
  hb_switch_ctrl #(.LP_PERIOD_MAX(16'h00C8)) dut (.clk, .rst, .address,
    .read, .write, .writedata, .readdata, .waitrequest, .capSense,
    .fbCurrent, .startSetting, .hbPeak, .resCurrentNeg, .overcurrentDetect,
    .nearCapacitive, .lowSideGate, .highSideGate, .lowPowerMode,
    .burstRequest);
  hb_far_side far (.clk, .rst, .ls(lowSideGate), .hs(highSideGate),
    .peakOff, .resBlock, .cap(capModel), .peak(hbPeak),
    .resNeg(resCurrentNeg));
  task automatic give_verdict();
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Cycle counts are judged against a window, not one value
  task automatic chkR(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("Error at %0t: got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask
  // Avalon master: request held until waitrequest seen low at an edge
  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'h0 && n < 50);
    if (waitrequest !== 1'h0) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, waitrequest, 1'h0);
    end
    rd = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return lowSideGate;
      1: return highSideGate;
      2: return lowPowerMode;
      3: return burstRequest;
      default: return lowSideGate | highSideGate;
    endcase
  endfunction
  // Counts cycles until an output reaches a level; bounded
  task automatic span(input int s, input logic v, input int lim);
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (sig(s) !== v && t < lim);
    if (sig(s) !== v) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, sig(s), v);
    end
  endtask
  // Off state and register values after reset
  task automatic t_reset();
    logic [31:0] rv [7];
    rv = '{32'h0, 32'(LP_LEVEL_RST), 32'(TON_MIN_RST), 32'(TON_MAX_RST),
           32'(TNO_MIN_RST), 32'(TNO_MAX_RST), 32'h0};
    chk({lowSideGate, highSideGate, lowPowerMode, burstRequest,
         waitrequest}, 32'h11);
    for (int i = 0; i < 7; i++) begin
      bus(1'h0, 3'(i), 32'h0);
      chk(rd, rv[i]);
    end
  endtask
  // Timing limits are writable; status words ignore writes
  task automatic t_regs();
    bus(1'h1, REG_TON_MIN, 32'(TMIN));
    bus(1'h1, REG_TON_MAX, 32'(TMAX));
    bus(1'h1, REG_TNO_MAX, 32'(NMAX));
    bus(1'h1, REG_STATUS, 32'hFF);
    bus(1'h0, REG_TON_MIN, 32'h0);
    chk(rd, 32'(TMIN));
    bus(1'h0, REG_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask
  // Enable with sense held low: strap spread, then maximum on-time
  task automatic t_start();
    chk(lowSideGate, 1'h1);
    bus(1'h1, REG_CTRL, 32'h1);
    span(0, 1'h0, 400);
    bus(1'h0, REG_THRESH, 32'h0);
    chk(rd, 32'h03BE0042);
    span(1, 1'h1, 100);
    span(1, 1'h0, 400);
    chkR(t, TMAX, TMAX + 2);
  endtask
  // Non-overlap waits, minimum on-time and early conduction ends
  task automatic t_cycle();
    @(posedge clk) resBlock <= 1'h1;
    repeat (3 * NMAX) @(posedge clk);
    chk({lowSideGate, highSideGate}, 32'h0);
    peakOff <= 1'h1;
    resBlock <= 1'h0;
    span(0, 1'h1, 10);
    chkR(t, 1, 3);
    span(0, 1'h0, 400);
    chkR(t, TMIN, TMIN + 2);
    span(1, 1'h1, 400);
    chkR(t, NMAX, NMAX + 2);
    @(posedge clk) capFix <= 10'h3FF;
    span(1, 1'h0, 400);
    chkR(t, TMIN, TMIN + 2);
    @(posedge clk) peakOff <= 1'h0;
    span(0, 1'h1, 400);
    chkR(t, NMIN, NMIN + 2);
    @(posedge clk) capFix <= 10'h200;
    repeat (TMIN + 4) @(posedge clk);
    overcurrentDetect <= 1'h1;
    span(0, 1'h0, 10);
    chkR(t, 1, 3);
    @(posedge clk) overcurrentDetect <= 1'h0;
    span(1, 1'h1, 400);
    @(posedge clk) nearCapacitive <= 1'h1;
    span(1, 1'h0, 400);
    chkR(t, TMIN, TMIN + 2);
    @(posedge clk) nearCapacitive <= 1'h0;
  endtask
  // Free-running tank: ramped spread, then a lighter demand
  task automatic t_ramp();
    @(posedge clk) useModel <= 1'h1;
    repeat (2000) @(posedge clk);
    bus(1'h0, REG_THRESH, 32'h0);
    chk(rd, 32'h03C00040);
    @(posedge clk) fbCurrent <= FB_TARGET + 10'h155;
    repeat (2000) @(posedge clk);
    bus(1'h0, REG_THRESH, 32'h0);
    chk(rd, 32'h032A00D6);
  endtask
  // Light load: low-power entry, cycle shape, hand-off to burst
  task automatic t_lp();
    @(posedge clk) fbCurrent <= FB_FULL;
    span(2, 1'h1, 3000);
    chk(lowPowerMode, 1'h1);
    span(0, 1'h0, 400);
    span(1, 1'h1, 400);
    span(1, 1'h0, 400);
    span(0, 1'h1, 400);
    span(0, 1'h0, 400);
    span(4, 1'h1, 4000);
    chk(highSideGate, 1'h0);
    chkR(t, NMIN + 3, 4000);
    bus(1'h0, REG_THRESH, 32'h0);
    chk(rd, 32'h022001E0);
    span(3, 1'h1, 4000);
    chk(burstRequest, 1'h1);
  endtask
  // Reset, then the scenarios in order
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_regs();
    t_start();
    t_cycle();
    t_ramp();
    t_lp();
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule // tb_hb_switch_ctrl
`default_nettype wire
